// *** hw/motor_var_pkg.sv ***
// Constants, bit layout and carrier types of the host variable block
`default_nettype none
package motor_var_pkg;
	// ****************************************
	// Host addresses
	// ****************************************
	localparam logic [15:0] A_CMD = 16'h1000;
	localparam logic [15:0] A_DEAD = 16'h0036;
	localparam logic [15:0] A_ACCEL = 16'h0060;
	localparam logic [15:0] A_SPEED = 16'h0062;
	localparam logic [15:0] A_UV = 16'h0066;
	localparam logic [15:0] A_OV = 16'h0068;
	localparam logic [15:0] A_VBUS = 16'h0079;
	localparam logic [15:0] A_ACTF = 16'h0085;
	localparam logic [15:0] A_SPDADC = 16'h0095;
	localparam logic [15:0] A_STATUS = 16'h00C8;
	localparam logic [15:0] A_SETUP = 16'h00AE;
	localparam logic [15:0] A_SWITCH = 16'h0001;
	localparam logic [15:0] A_RSTCAUSE = 16'hFE01;
	// ****************************************
	// Command codes
	// ****************************************
	localparam logic [7:0] C_RESET = 8'h30;
	localparam logic [7:0] C_F5K3 = 8'h41;
	localparam logic [7:0] C_F10K6 = 8'h42;
	localparam logic [7:0] C_F15K9 = 8'h44;
	localparam logic [7:0] C_F21K1 = 8'h48;
	localparam logic [7:0] C_POL_PP = 8'h50;
	localparam logic [7:0] C_POL_PN = 8'h54;
	localparam logic [7:0] C_POL_NP = 8'h58;
	localparam logic [7:0] C_POL_NN = 8'h5C;
	localparam logic [7:0] C_BASE60 = 8'h60;
	localparam logic [7:0] C_BASE50 = 8'h61;
	localparam logic [7:0] PWM_DEFAULT = C_F15K9;
	localparam logic [4:0] SETUP_MASK = 5'h1F;
	localparam logic [2:0] SETUP_PAD = 3'h7;
	localparam logic [2:0] LVL_AGREE = 3'h3;
	// ****************************************
	// Bit layouts, most significant first
	// ****************************************
	typedef struct packed {
		logic pad;
		logic uv_trip;
		logic ov_trip;
		logic ext_trip;
		logic brake;
		logic energized;
		logic forward;
		logic changing;
	} status_t;
	typedef struct packed {
		logic dead_set;
		logic pol_set;
		logic accel_set;
		logic speed_set;
		logic base_set;
	} setup_t;
	typedef struct packed {
		logic low_vdd;
		logic host_cmd;
		logic func_err;
		logic pin;
		logic power_up;
	} cause_t;
	// Motion engine state seen by the status byte
	typedef struct packed {
		logic changing;
		logic forward;
		logic energized;
		logic brake;
	} motion_t;
endpackage
`default_nettype wire

// *** hw/motor_host_vars.sv ***
// Host-visible variable, setup and status bank of the motor controller
`default_nettype none
module motor_host_vars
	import motor_var_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Host byte access, one-cycle request strobes
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	output logic [7:0] host_rdata_o,
	output logic host_ack_o,
	output logic host_illegal_o,
	output logic host_reset_req_o,
	// Motion engine, converter and fault timer
	input wire motion_t motion_i,
	input wire logic [15:0] actual_freq_i,
	input wire logic [9:0] bus_sense_in,
	input wire logic [15:0] speed_adc_i,
	input wire logic fault_timer_running_i,
	input wire logic deadtime_fault_pin_i,
	// Pins from outside the clock domain
	input wire logic start_stop_in,
	input wire logic direction_in,
	input wire logic external_fault_in,
	// Reset cause from the reset controller, held stable
	input wire cause_t reset_cause_i,
	// Parameters to the engine
	output logic pwm_hiz_o,
	output logic motion_permit_o,
	output logic [7:0] dead_time_o,
	output logic [7:0] polarity_o,
	output logic [7:0] pwm_freq_o,
	output logic [7:0] base_freq_o,
	output logic [15:0] accel_o,
	output logic [15:0] speed_cmd_o,
	output logic [2:0] trip_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [2:0][2:0] sync;
		logic [2:0] lvl;
		setup_t setup;
		logic [7:0] dead;
		logic [7:0] pol;
		logic [7:0] pwm;
		logic [7:0] base;
		logic [15:0] accel;
		logic [15:0] speed;
		logic [9:0] uv_thr;
		logic [9:0] ov_thr;
		logic [7:0] hi;
		cause_t cause;
		logic captured;
		logic cause_read;
		logic [2:0] trip;
		logic [7:0] rdata;
		logic ack;
		logic illegal;
		logic rst_req;
	} state_t;

	localparam state_t STATE_RST = '{pwm: PWM_DEFAULT, default: '0};

	state_t st_r;
	state_t st_nxt;
	logic hiz;
	logic ov_cond;
	logic uv_cond;
	logic [2:0] cond;
	status_t status;
	logic [7:0] sw_byte;
	logic [7:0] cmd;
	logic wr_cmd;

	// Outputs float until both write-once values are in
	assign hiz = !(st_r.setup.dead_set && st_r.setup.pol_set);
	// Converter readings count only after the outputs are driven
	assign ov_cond = !hiz && (bus_sense_in > st_r.ov_thr);
	assign uv_cond = !hiz && (bus_sense_in < st_r.uv_thr);
	assign cond = {uv_cond, ov_cond, st_r.lvl[2]};
	assign cmd = host_wdata_i;
	assign wr_cmd = host_wr_i && (host_addr_i == A_CMD);

	// Status byte layout, bit 7 reads zero
	always_comb begin
		status.pad = 1'b0;
		status.changing = motion_i.changing;
		status.forward = motion_i.forward;
		status.energized = motion_i.energized;
		status.brake = motion_i.brake;
		status.ext_trip = st_r.trip[0];
		status.ov_trip = st_r.trip[1];
		status.uv_trip = st_r.trip[2];
	end

	// Switch byte: start, direction, fault out, brake
	assign sw_byte = {4'h0, motion_i.brake, deadtime_fault_pin_i,
		st_r.lvl[1], st_r.lvl[0]};

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = 1'b0;
		st_nxt.illegal = 1'b0;
		st_nxt.rst_req = 1'b0;
		// Three stages; a level moves once the last two agree
		st_nxt.sync = {st_r.sync[1:0], {external_fault_in, direction_in,
			start_stop_in}};
		for (int i = 0; i < 3; i++) begin
			if (st_r.sync[1][i] == st_r.sync[2][i]) begin
				st_nxt.lvl[i] = st_r.sync[2][i];
			end
		end
		// Cause is a port, so it is caught one edge after release
		if (!st_r.captured) begin
			st_nxt.captured = 1'b1;
			st_nxt.cause = reset_cause_i;
		end
		// Trips hold while the timeout runs; a new cause wins
		for (int i = 0; i < 3; i++) begin
			if (cond[i]) begin
				st_nxt.trip[i] = 1'b1;
			end else if (!fault_timer_running_i) begin
				st_nxt.trip[i] = 1'b0;
			end
		end
		// Host writes; 16-bit values commit on the low byte
		if (host_wr_i) begin
			st_nxt.ack = 1'b1;
			st_nxt.hi = host_wdata_i;
			unique case (host_addr_i)
				A_DEAD: begin
					if (st_r.setup.dead_set) begin
						st_nxt.illegal = 1'b1;
					end else begin
						st_nxt.dead = host_wdata_i;
						st_nxt.setup.dead_set = 1'b1;
					end
				end
				A_ACCEL + 16'h0001: begin
					st_nxt.accel = {st_r.hi, host_wdata_i};
					st_nxt.setup.accel_set = 1'b1;
				end
				A_SPEED + 16'h0001: begin
					st_nxt.speed = {st_r.hi, host_wdata_i};
					st_nxt.setup.speed_set = 1'b1;
				end
				A_UV + 16'h0001: begin
					st_nxt.uv_thr = {st_r.hi[1:0], host_wdata_i};
				end
				A_OV + 16'h0001: begin
					st_nxt.ov_thr = {st_r.hi[1:0], host_wdata_i};
				end
				A_CMD: begin
					unique case (cmd)
						C_RESET: begin
							st_nxt.rst_req = 1'b1;
						end
						C_F5K3, C_F10K6, C_F15K9, C_F21K1: begin
							if (hiz) begin
								st_nxt.illegal = 1'b1;
							end else begin
								st_nxt.pwm = cmd;
							end
						end
						C_POL_PP, C_POL_PN, C_POL_NP, C_POL_NN: begin
							if (st_r.setup.pol_set) begin
								st_nxt.illegal = 1'b1;
							end else begin
								st_nxt.pol = cmd;
								st_nxt.setup.pol_set = 1'b1;
							end
						end
						C_BASE60, C_BASE50: begin
							st_nxt.base = cmd;
							st_nxt.setup.base_set = 1'b1;
						end
						default: begin
							st_nxt.illegal = 1'b1;
						end
					endcase
				end
				default: begin
				end
			endcase
		end else if (host_rd_i) begin
			st_nxt.ack = 1'b1;
			unique case (host_addr_i)
				A_STATUS: st_nxt.rdata = status;
				A_SETUP: st_nxt.rdata = {SETUP_PAD, st_r.setup};
				A_SWITCH: st_nxt.rdata = sw_byte;
				A_RSTCAUSE: begin
					// Only the first read sees the cause
					st_nxt.rdata = st_r.cause_read ? 8'h00 :
						{3'h0, st_r.cause};
					st_nxt.cause_read = 1'b1;
				end
				A_DEAD: st_nxt.rdata = st_r.dead;
				A_ACCEL: st_nxt.rdata = st_r.accel[15:8];
				A_ACCEL + 16'h0001: st_nxt.rdata = st_r.accel[7:0];
				A_SPEED: st_nxt.rdata = st_r.speed[15:8];
				A_SPEED + 16'h0001: st_nxt.rdata = st_r.speed[7:0];
				A_ACTF: st_nxt.rdata = actual_freq_i[15:8];
				A_ACTF + 16'h0001: st_nxt.rdata = actual_freq_i[7:0];
				// Readings masked to zero while floating
				A_VBUS: st_nxt.rdata = hiz ? 8'h00 :
					{6'h00, bus_sense_in[9:8]};
				A_VBUS + 16'h0001: st_nxt.rdata = hiz ? 8'h00 :
					bus_sense_in[7:0];
				A_SPDADC: st_nxt.rdata = hiz ? 8'h00 : speed_adc_i[15:8];
				A_SPDADC + 16'h0001: st_nxt.rdata = hiz ? 8'h00 :
					speed_adc_i[7:0];
				A_UV: st_nxt.rdata = {6'h00, st_r.uv_thr[9:8]};
				A_UV + 16'h0001: st_nxt.rdata = st_r.uv_thr[7:0];
				A_OV: st_nxt.rdata = {6'h00, st_r.ov_thr[9:8]};
				A_OV + 16'h0001: st_nxt.rdata = st_r.ov_thr[7:0];
				default: st_nxt.rdata = 8'h00;
			endcase
		end
	end

	// Single state register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_r <= STATE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign host_rdata_o = st_r.rdata;
	assign host_ack_o = st_r.ack;
	assign host_illegal_o = st_r.illegal;
	assign host_reset_req_o = st_r.rst_req;
	assign pwm_hiz_o = hiz;
	assign motion_permit_o = (st_r.setup == SETUP_MASK);
	assign dead_time_o = st_r.dead;
	assign polarity_o = st_r.pol;
	assign pwm_freq_o = st_r.pwm;
	assign base_freq_o = st_r.base;
	assign accel_o = st_r.accel;
	assign speed_cmd_o = st_r.speed;
	assign trip_o = st_r.trip;

	// ****************************************
	// Assertions
	// ****************************************
	property p_freq_reject;
		@(posedge clk_i) disable iff (!rstn_i)
		wr_cmd && hiz && (cmd[7:4] == C_F5K3[7:4]) |=> // Any rate code
			host_illegal_o && (pwm_freq_o == $past(pwm_freq_o));
	endproperty
	a_freq_reject: assert property (p_freq_reject)
		else $error("PWM frequency taken while outputs float");

	property p_hiz_exit;
		@(posedge clk_i) disable iff (!rstn_i)
		$fell(pwm_hiz_o) |-> $past(host_wr_i) &&
			($past(host_addr_i) == A_DEAD || $past(host_addr_i) == A_CMD);
	endproperty
	a_hiz_exit: assert property (p_hiz_exit)
		else $error("Outputs left float without a parameter write");

	property p_motion;
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(motion_permit_o) |-> $past(host_wr_i) && !pwm_hiz_o;
	endproperty
	a_motion: assert property (p_motion)
		else $error("Motion permitted without parameter write");

	property p_once;
		@(posedge clk_i) disable iff (!rstn_i)
		host_wr_i && host_addr_i == A_DEAD && st_r.setup.dead_set |=>
			host_illegal_o && $stable(dead_time_o);
	endproperty
	a_once: assert property (p_once)
		else $error("Second dead time write not refused");

	property p_vbus_mask;
		@(posedge clk_i) disable iff (!rstn_i)
		!host_wr_i && host_rd_i && host_addr_i == A_VBUS && hiz
			|=> host_ack_o && host_rdata_o == 8'h00;
	endproperty
	a_vbus_mask: assert property (p_vbus_mask)
		else $error("Bus reading shown while outputs float");

	property p_cause_once;
		@(posedge clk_i) disable iff (!rstn_i)
		!host_wr_i && host_rd_i && host_addr_i == A_RSTCAUSE &&
			st_r.cause_read |=> host_ack_o && host_rdata_o == 8'h00;
	endproperty
	a_cause_once: assert property (p_cause_once)
		else $error("Reset cause returned twice");

	property p_changing;
		@(posedge clk_i) disable iff (!rstn_i)
		!host_wr_i && host_rd_i && host_addr_i == A_STATUS |=>
			host_rdata_o[0] == $past(motion_i.changing) &&
			host_rdata_o[1] == $past(motion_i.forward);
	endproperty
	a_changing: assert property (p_changing)
		else $error("Status byte does not follow motion state");

	property p_ov_clear;
		@(posedge clk_i) disable iff (!rstn_i)
		!fault_timer_running_i && !ov_cond |=> !trip_o[1];
	endproperty
	a_ov_clear: assert property (p_ov_clear)
		else $error("Over-voltage trip held without timeout");

	property p_reset_cmd;
		@(posedge clk_i) disable iff (!rstn_i)
		wr_cmd && cmd == C_RESET |=> host_reset_req_o ##1 !host_reset_req_o;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd)
		else $error("Reset command not passed on as one pulse");
endmodule
`default_nettype wire

// *** verif/host_sw_model.sv ***
// Host software model issuing byte reads and writes
`default_nettype none
module host_sw_model
	import motor_var_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Host byte port
	output logic wr_o,
	output logic rd_o,
	output logic [15:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i,
	input wire logic ack_i,
	input wire logic illegal_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Idle bus
	// ****************************************
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 16'h0000;
		wdata_o = 8'h00;
	end
	// One-cycle strobe, answer taken while the ack pulse stands
	task automatic xfer(input logic wr, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ill,
		output logic ok);
		@(negedge clk_i);
		wr_o = wr;
		rd_o = ~wr;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Released lines flip so a stale value can never pass
		addr_o = ~a;
		wdata_o = ~d;
		ok = (ack_i === 1'b1);
		ill = (illegal_i === 1'b1);
		q = rdata_i;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_motor_host_vars.sv ***
// Self-checking bench of the host variable bank
`default_nettype none
module tb_motor_host_vars;
	import motor_var_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic wr, rd, ack, ill, rreq, tmr, dtf, start, dir, extf, hiz, permit;
	logic seen_rreq = 1'b0;
	logic [15:0] addr, afreq, spd, accel, spdc;
	logic [7:0] wdata, rdata, dead, pol, pwmf, basef;
	logic [9:0] bus = 10'h2A5;
	logic [2:0] trip;
	motion_t motion = 4'h0;
	cause_t cause = 5'h03;
	int n_mismatch = 0;
	int n_compared = 0;
	initial begin
		{tmr, dtf, start, dir, extf} = 5'h00;
		afreq = 16'h0000;
		spd = 16'hABC0;
	end
	// Clock, 10 ns period
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Reset request is a single pulse, so latch it here
	always @(posedge clk_i) begin
		if (rreq === 1'b1) seen_rreq <= 1'b1;
	end
	motor_host_vars motor_host_vars_inst (.clk_i(clk_i), .rstn_i(rstn_i),
		.host_wr_i(wr), .host_rd_i(rd), .host_addr_i(addr),
		.host_wdata_i(wdata), .host_rdata_o(rdata), .host_ack_o(ack),
		.host_illegal_o(ill), .host_reset_req_o(rreq), .motion_i(motion),
		.actual_freq_i(afreq), .bus_sense_in(bus), .speed_adc_i(spd),
		.fault_timer_running_i(tmr), .deadtime_fault_pin_i(dtf),
		.start_stop_in(start), .direction_in(dir), .external_fault_in(extf),
		.reset_cause_i(cause), .pwm_hiz_o(hiz), .motion_permit_o(permit),
		.dead_time_o(dead), .polarity_o(pol), .pwm_freq_o(pwmf),
		.base_freq_o(basef), .accel_o(accel), .speed_cmd_o(spdc),
		.trip_o(trip));
	host_sw_model host_sw_model_inst (.clk_i(clk_i), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wdata), .rdata_i(rdata), .ack_i(ack),
		.illegal_i(ill));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic [15:0] a, input logic [7:0] d,
		input logic ei);
		logic [7:0] q;
		logic i;
		logic ok;
		host_sw_model_inst.xfer(1'b1, a, d, q, i, ok);
		chk({ok, i}, {1'b1, ei});
	endtask
	task automatic rb(input logic [15:0] a, input logic [7:0] e);
		logic [7:0] q;
		logic i;
		logic ok;
		host_sw_model_inst.xfer(1'b0, a, 8'h00, q, i, ok);
		chk({ok, q}, {1'b1, e});
	endtask
	// Reset held six cycles; first request strobed three edges after release
	task automatic do_reset(input cause_t c);
		@(negedge clk_i);
		rstn_i = 1'b0;
		cause = c;
		repeat (6) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_after_reset();
		chk({hiz, pwmf}, {1'b1, PWM_DEFAULT});
		rb(A_RSTCAUSE, 8'h03);
		rb(A_RSTCAUSE, 8'h00);
		rb(A_VBUS, 8'h00);
		rb(A_SPDADC + 16'h1, 8'h00);
		rb(16'h0500, 8'h00);
	endtask
	task automatic t_write_once();
		logic [7:0] f [4] = '{C_F5K3, C_F10K6, C_F15K9, C_F21K1};
		wb(A_CMD, C_F21K1, 1'b1);
		chk(pwmf, PWM_DEFAULT);
		wb(A_DEAD, 8'h20, 1'b0);
		wb(A_DEAD, 8'h40, 1'b1);
		chk({hiz, dead}, {1'b1, 8'h20});
		rb(A_DEAD, 8'h20);
		wb(A_CMD, C_POL_PN, 1'b0);
		wb(A_CMD, C_POL_NN, 1'b1);
		chk({hiz, pol}, {1'b0, C_POL_PN});
		foreach (f[k]) begin
			wb(A_CMD, f[k], 1'b0);
			chk(pwmf, f[k]);
		end
		rb(A_SETUP, 8'hF8);
	endtask
	task automatic t_params();
		chk(permit, 1'b0);
		wb(A_CMD, C_BASE60, 1'b0);
		chk(basef, C_BASE60);
		wb(A_CMD, C_BASE50, 1'b0);
		chk(basef, C_BASE50);
		wb(A_CMD, 8'h99, 1'b1);
		wb(A_ACCEL, 8'h7F, 1'b0);
		wb(A_ACCEL + 16'h1, 8'hFF, 1'b0);
		chk(accel, 16'h7FFF);
		rb(A_ACCEL, 8'h7F);
		rb(A_ACCEL + 16'h1, 8'hFF);
		rb(A_SETUP, 8'hFD);
		chk(permit, 1'b0);
		wb(A_SPEED, 8'h12, 1'b0);
		wb(A_SPEED + 16'h1, 8'h80, 1'b0);
		chk({permit, spdc}, {1'b1, 16'h1280});
		rb(A_SPEED, 8'h12);
		rb(A_SETUP, 8'hFF);
	endtask
	task automatic t_status();
		motion = '{changing: 1'b1, forward: 1'b1, energized: 1'b0,
			brake: 1'b1};
		{start, dir, dtf} = 3'b101;
		afreq = 16'h1A40;
		pause(8);
		// Over-voltage trip stands: zero threshold, bus above it
		rb(A_STATUS, 8'h2B);
		rb(A_SWITCH, 8'h0D);
		motion = '{changing: 1'b0, forward: 1'b0, energized: 1'b1,
			brake: 1'b0};
		{start, dir, dtf} = 3'b010;
		pause(8);
		rb(A_STATUS, 8'h24);
		rb(A_SWITCH, 8'h02);
		rb(A_ACTF, 8'h1A);
		rb(A_ACTF + 16'h1, 8'h40);
		rb(A_VBUS, 8'h02);
		rb(A_VBUS + 16'h1, 8'hA5);
		rb(A_SPDADC, 8'hAB);
		rb(A_SPDADC + 16'h1, 8'hC0);
	endtask
	task automatic t_trips();
		tmr = 1'b1;
		wb(A_OV, 8'h01, 1'b0);
		wb(A_OV + 16'h1, 8'h00, 1'b0);
		rb(A_OV, 8'h01);
		rb(A_OV + 16'h1, 8'h00);
		pause(3);
		chk(trip, 3'b010);
		rb(A_STATUS, 8'h24);
		bus = 10'h080;
		pause(3);
		chk(trip, 3'b010);
		tmr = 1'b0;
		pause(3);
		chk(trip, 3'b000);
		extf = 1'b1;
		pause(8);
		chk(trip, 3'b001);
		tmr = 1'b1;
		extf = 1'b0;
		pause(8);
		chk(trip, 3'b001);
		tmr = 1'b0;
		pause(3);
		chk(trip, 3'b000);
		wb(A_UV, 8'h02, 1'b0);
		wb(A_UV + 16'h1, 8'h00, 1'b0);
		rb(A_UV, 8'h02);
		pause(3);
		chk(trip, 3'b100);
		rb(A_STATUS, 8'h44);
	endtask
	task automatic t_reset_cmd();
		wb(A_CMD, C_RESET, 1'b0);
		pause(1);
		chk(seen_rreq, 1'b1);
		do_reset(5'h08);
		rb(A_RSTCAUSE, 8'h08);
		rb(A_RSTCAUSE, 8'h00);
		wb(A_DEAD, 8'h33, 1'b0);
		chk(dead, 8'h33);
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset(5'h03);
		t_after_reset();
		t_write_once();
		t_params();
		t_status();
		t_trips();
		t_reset_cmd();
		wrap_up();
	end
endmodule
`default_nettype wire
